//--- pkg/spi_gate_pkg.sv
// Purpose: constants and types for the serial port transmit gate and status block
// Assumes: apb with 32-bit data, word registers at byte address = index * 4
// Notes: register indexes, field positions, reset values and timing counts live here
// Behaviour
// - output drive enable at 0 floats the serial data output, master or slave.
// - slave with drive off floats peripheral-out line unless pin is general-purpose.
// - master with drive off floats controller-out line unless pin is general-purpose.
// - dropping drive enable mid-character lets the shifter finish that character.
// - with drive off, receiving and all status flag updates carry on.
// - system reset clears the output drive enable bit.
// - transfer irq enable gates only the request, never the transfer-complete flag.
// - receive-lost flag, status bit 7, sets when an unread character is overwritten.
// - receive-lost clears by writing 1, soft reset low, or system reset.
// - lost interrupt requested once, on the flag's 0 to 1 change only.
// - lost and transfer-complete interrupts share one request output.
// - writing 0 to status bits 5, 6 or 7 changes nothing.
// - status: bit 7 lost, bit 6 complete, bit 5 tx full, bits 4-0 zero.
// - operation control bit 4 enables the lost interrupt; 0 suppresses it.
// - complete flag sets at a character's last bit; rx holding loads same cycle.
// - tx full sets on tx holding write, clears when data moves to shifter.
package spi_gate_pkg;
    localparam logic [31:0] idx_config = 32'h0000_7040;
    localparam logic [31:0] idx_op_ctl = 32'h0000_7041;
    localparam logic [31:0] idx_status = 32'h0000_7042;
    localparam logic [31:0] idx_rx_hold = 32'h0000_7047;
    localparam logic [31:0] idx_tx_hold = 32'h0000_7048;
    localparam logic [31:0] idx_irq_status = 32'h0000_7050;
    localparam logic [31:0] idx_irq_mask = 32'h0000_7051;
    localparam logic [31:0] idx_pin_cfg = 32'h0000_7052;
    localparam int unsigned char_bits = 8;
    localparam logic [7:0] op_ctl_reset = 8'h00;
    localparam logic [7:0] config_reset = 8'h00;
    localparam logic [1:0] irq_mask_reset = 2'h3;
    localparam logic [1:0] pin_cfg_reset = 2'h0;
    localparam int unsigned soft_reset_bit = 7;
    localparam int unsigned clk_period_ns = 8;
    localparam int unsigned half_bit_ns = 32;
    localparam int unsigned half_bit_cycles = (half_bit_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int unsigned irq_bit_xfer = 0;
    localparam int unsigned irq_bit_lost = 1;

    typedef struct packed {
        logic [2:0] reserved;
        logic lost_irq_enable;
        logic clock_phase;
        logic master_mode;
        logic output_drive_enable;
        logic xfer_irq_enable;
    } op_ctl_t;

    typedef struct packed {
        logic rx_lost;
        logic xfer_done;
        logic tx_full;
        logic [4:0] zero;
    } status_t;

    typedef struct packed {
        logic data_in;
        logic data_out;
        logic data_oe;
    } pin_t;
endpackage

//--- core/spi_transmit_gate_and_status.sv
// Purpose: serial port transmit gate, status word, shared interrupt and apb registers
// Assumes: pins synchronous to pclk; fixed 8-bit characters, msb first
// Notes: shifter paced by an internal half-bit enable as master, by the clock pin as slave
//
// Added by the designer: the APB slave port.
module spi_transmit_gate_and_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ctrl_out_line_in,
    output logic ctrl_out_line_out,
    output logic ctrl_out_line_oe,
    input wire logic periph_out_line_in,
    output logic periph_out_line_out,
    output logic periph_out_line_oe,
    input wire logic serial_clk_in,
    output logic serial_clk_out,
    output logic serial_clk_oe,
    output logic irq
);
    // bus decode
    wire logic [31:0] word_idx = {2'b00, paddr[31:2]};
    wire logic sel_config = word_idx == spi_gate_pkg::idx_config;
    wire logic sel_op_ctl = word_idx == spi_gate_pkg::idx_op_ctl;
    wire logic sel_status = word_idx == spi_gate_pkg::idx_status;
    wire logic sel_rx = word_idx == spi_gate_pkg::idx_rx_hold;
    wire logic sel_tx = word_idx == spi_gate_pkg::idx_tx_hold;
    wire logic sel_irq_st = word_idx == spi_gate_pkg::idx_irq_status;
    wire logic sel_irq_mask = word_idx == spi_gate_pkg::idx_irq_mask;
    wire logic sel_pin = word_idx == spi_gate_pkg::idx_pin_cfg;
    wire logic mapped = sel_config | sel_op_ctl | sel_status | sel_rx | sel_tx
                        | sel_irq_st | sel_irq_mask | sel_pin;
    wire logic misaligned = paddr[1:0] != 2'b00;
    wire logic acc = psel & penable;
    wire logic setup = psel & ~penable;
    wire logic ok = mapped & ~misaligned;
    wire logic wr = acc & pwrite & ok;
    wire logic rd = acc & ~pwrite & ok;
    wire logic wr_config = wr & sel_config;
    wire logic wr_op_ctl = wr & sel_op_ctl;
    wire logic wr_status = wr & sel_status;
    wire logic wr_tx = wr & sel_tx;
    wire logic wr_irq_st = wr & sel_irq_st;
    wire logic wr_irq_mask = wr & sel_irq_mask;
    wire logic wr_pin = wr & sel_pin;
    wire logic rd_rx = rd & sel_rx;

    // registers
    logic [7:0] config_r;
    spi_gate_pkg::op_ctl_t op_ctl_r;
    logic [1:0] irq_mask_r;
    logic [1:0] pin_cfg_r;
    logic [7:0] tx_holding_r;
    logic [7:0] rx_holding_r;
    logic tx_full_r;
    logic xfer_done_r;
    logic rx_lost_r;
    logic rx_unread_r;
    logic lost_pend_r;
    logic xfer_seen_r;

    // shifter
    logic [7:0] tx_shift_r;
    logic [7:0] rx_shift_r;
    logic [3:0] bit_cnt_r;
    logic loaded_r;
    logic sclk_r;
    logic sclk_in_d_r;
    logic [7:0] half_cnt_r;

    wire logic soft_reset_n = config_r[spi_gate_pkg::soft_reset_bit];
    wire logic is_master = op_ctl_r.master_mode;
    wire logic gpio_ctrl_pin = pin_cfg_r[0];
    wire logic gpio_periph_pin = pin_cfg_r[1];

    // half-bit enable, runs only while a master character is in flight
    wire logic half_tick = half_cnt_r == 8'(spi_gate_pkg::half_bit_cycles - 1);
    wire logic m_run = soft_reset_n & is_master & loaded_r;
    wire logic m_rise = m_run & half_tick & ~sclk_r;
    wire logic m_fall = m_run & half_tick & sclk_r;
    wire logic s_rise = soft_reset_n & ~is_master & serial_clk_in & ~sclk_in_d_r;
    wire logic s_fall = soft_reset_n & ~is_master & ~serial_clk_in & sclk_in_d_r;
    wire logic rise_ev = is_master ? m_rise : s_rise;
    wire logic fall_ev = is_master ? m_fall : s_fall;
    wire logic data_in = is_master ? periph_out_line_in : ctrl_out_line_in;
    wire logic last_bit = bit_cnt_r == 4'(spi_gate_pkg::char_bits - 1);
    wire logic char_done = rise_ev & last_bit;
    wire logic [7:0] rx_next = {rx_shift_r[6:0], data_in};
    // shifter keeps running whatever the drive enable says
    wire logic load_tx = soft_reset_n & tx_full_r & ~loaded_r & (bit_cnt_r == 4'h0)
                         & ~rise_ev & ~fall_ev;
    wire logic lost_set = char_done & rx_unread_r & ~rd_rx;
    wire logic lost_rise = lost_set & ~rx_lost_r;

    // apb slave answers at once
    assign pready = 1'b1;
    assign pslverr = acc & ~ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_r <= spi_gate_pkg::config_reset;
        end else if (wr_config) begin
            config_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_ctl_r <= spi_gate_pkg::op_ctl_reset;
        end else if (wr_op_ctl) begin
            op_ctl_r <= {3'h0, pwdata[4:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= spi_gate_pkg::irq_mask_reset;
            pin_cfg_r <= spi_gate_pkg::pin_cfg_reset;
        end else begin
            if (wr_irq_mask) begin
                irq_mask_r <= pwdata[1:0];
            end
            if (wr_pin) begin
                pin_cfg_r <= pwdata[1:0];
            end
        end
    end

    // tx holding and its full flag; a fresh write wins over the load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_holding_r <= 8'h00;
            tx_full_r <= 1'b0;
        end else if (!soft_reset_n) begin
            tx_full_r <= tx_full_r | wr_tx;
            if (wr_tx) begin
                tx_holding_r <= pwdata[7:0];
            end
        end else if (wr_tx) begin
            tx_holding_r <= pwdata[7:0];
            tx_full_r <= 1'b1;
        end else if (load_tx) begin
            tx_full_r <= 1'b0;
        end
    end

    // receive holding and transfer-complete flag, set wins over rx read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_holding_r <= 8'h00;
            xfer_done_r <= 1'b0;
            rx_unread_r <= 1'b0;
        end else if (!soft_reset_n) begin
            xfer_done_r <= 1'b0;
            rx_unread_r <= 1'b0;
        end else if (char_done) begin
            rx_holding_r <= rx_next;
            xfer_done_r <= 1'b1;
            rx_unread_r <= 1'b1;
        end else if (rd_rx) begin
            xfer_done_r <= 1'b0;
            rx_unread_r <= 1'b0;
        end
    end

    // receive-lost flag; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_lost_r <= 1'b0;
        end else if (!soft_reset_n) begin
            rx_lost_r <= 1'b0;
        end else if (lost_set) begin
            rx_lost_r <= 1'b1;
        end else if (wr_status && pwdata[7]) begin
            rx_lost_r <= 1'b0;
        end
    end

    // sticky event bits, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost_pend_r <= 1'b0;
            xfer_seen_r <= 1'b0;
        end else if (!soft_reset_n) begin
            lost_pend_r <= 1'b0;
            xfer_seen_r <= 1'b0;
        end else begin
            if (lost_rise) begin
                lost_pend_r <= 1'b1;
            end else if ((wr_irq_st && pwdata[spi_gate_pkg::irq_bit_lost])
                         || (wr_status && pwdata[7])) begin
                lost_pend_r <= 1'b0;
            end
            if (char_done) begin
                xfer_seen_r <= 1'b1;
            end else if (wr_irq_st && pwdata[spi_gate_pkg::irq_bit_xfer]) begin
                xfer_seen_r <= 1'b0;
            end
        end
    end

    // shared request
    wire logic xfer_req = xfer_done_r & op_ctl_r.xfer_irq_enable
                          & irq_mask_r[spi_gate_pkg::irq_bit_xfer];
    wire logic lost_req = lost_pend_r & op_ctl_r.lost_irq_enable
                          & irq_mask_r[spi_gate_pkg::irq_bit_lost];
    assign irq = xfer_req | lost_req;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt_r <= 8'h00;
            sclk_r <= 1'b0;
        end else if (!m_run) begin
            half_cnt_r <= 8'h00;
            sclk_r <= 1'b0;
        end else if (half_tick) begin
            half_cnt_r <= 8'h00;
            sclk_r <= ~sclk_r;
        end else begin
            half_cnt_r <= half_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_in_d_r <= 1'b0;
        end else begin
            sclk_in_d_r <= serial_clk_in;
        end
    end

    // bit engine: sample on rise, advance output on fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_shift_r <= 8'h00;
            rx_shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            loaded_r <= 1'b0;
        end else if (!soft_reset_n) begin
            tx_shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            loaded_r <= 1'b0;
        end else if (load_tx) begin
            tx_shift_r <= tx_holding_r;
            loaded_r <= 1'b1;
        end else begin
            if (rise_ev) begin
                rx_shift_r <= rx_next;
                bit_cnt_r <= last_bit ? 4'h0 : bit_cnt_r + 4'h1;
            end
            if (fall_ev) begin
                tx_shift_r <= {tx_shift_r[6:0], 1'b0};
                if (bit_cnt_r == 4'h0) begin
                    loaded_r <= 1'b0;
                end
            end
        end
    end

    // output gate; shifter untouched, only the data pin enables follow the bit
    wire logic drive = op_ctl_r.output_drive_enable;
    assign ctrl_out_line_out = tx_shift_r[7];
    assign periph_out_line_out = tx_shift_r[7];
    assign ctrl_out_line_oe = drive & is_master & ~gpio_ctrl_pin;
    assign periph_out_line_oe = drive & ~is_master & ~gpio_periph_pin;
    assign serial_clk_out = sclk_r;
    assign serial_clk_oe = is_master;

    // read data captured in the setup cycle
    spi_gate_pkg::status_t status_view;
    assign status_view = '{rx_lost: rx_lost_r, xfer_done: xfer_done_r,
                           tx_full: tx_full_r, zero: 5'h00};
    wire logic [7:0] rd_byte =
        sel_config ? config_r :
        sel_op_ctl ? op_ctl_r :
        sel_status ? status_view :
        sel_rx ? rx_holding_r :
        sel_tx ? tx_holding_r :
        sel_irq_st ? {6'h00, lost_pend_r, xfer_seen_r} :
        sel_irq_mask ? {6'h00, irq_mask_r} :
        sel_pin ? {6'h00, pin_cfg_r} : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= (!pwrite && ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end
endmodule

//--- bench/spi_far_end.sv
// Purpose: far-side serial slave that answers the block when the block is master
// Assumes: block clock idles low, samples on rise and shifts on fall, msb first
// Notes: a released controller-out line is seen as the flipped last level
module spi_far_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sclk,
    input wire logic din,
    input wire logic din_oe,
    input wire logic [7:0] tx_byte,
    output logic dout,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk_r;
    logic w_last_r;
    logic [2:0] cnt_r;
    logic [7:0] sr_r;
    logic [7:0] shin_r;
    wire rise = sclk & ~sclk_r;
    wire fall = ~sclk & sclk_r;
    wire w = din_oe ? din : ~w_last_r;
    assign dout = (cnt_r == 3'h0) ? tx_byte[7] : sr_r[7];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_r <= 1'b0;
            w_last_r <= 1'b0;
            cnt_r <= 3'h0;
            sr_r <= 8'h00;
            shin_r <= 8'h00;
            rx_byte <= 8'h00;
        end else begin
            sclk_r <= sclk;
            w_last_r <= w;
            if (rise) begin
                cnt_r <= cnt_r + 3'h1;
                shin_r <= {shin_r[6:0], w};
                if (cnt_r == 3'h0) sr_r <= tx_byte;
                if (cnt_r == 3'h7) rx_byte <= {shin_r[6:0], w};
            end
            if (fall) sr_r <= {sr_r[6:0], 1'b0};
        end
    end
endmodule

//--- bench/spi_gate_asserts.sv
// Purpose: port-level checks of pin gating, serial clock shape, status and irq
// Assumes: single pclk domain, presetn async active low
// Notes: bound onto the block below
module spi_gate_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ctrl_out_line_in,
    input wire logic ctrl_out_line_out,
    input wire logic ctrl_out_line_oe,
    input wire logic periph_out_line_in,
    input wire logic periph_out_line_out,
    input wire logic periph_out_line_oe,
    input wire logic serial_clk_in,
    input wire logic serial_clk_out,
    input wire logic serial_clk_oe,
    input wire logic irq
);
    localparam logic [31:0] st_addr = spi_gate_pkg::idx_status << 2;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_oe_exclusive; !(ctrl_out_line_oe && periph_out_line_oe); endproperty
    a_oe_exclusive: assert property (p_oe_exclusive) else $error("both outputs driven");
    property p_ctrl_master; ctrl_out_line_oe |-> serial_clk_oe; endproperty
    a_ctrl_master: assert property (p_ctrl_master) else $error("ctrl out driven as slave");
    property p_periph_slave; periph_out_line_oe |-> !serial_clk_oe; endproperty
    a_periph_slave: assert property (p_periph_slave) else $error("periph out as master");
    property p_reset_float; $rose(presetn) |-> !ctrl_out_line_oe && !periph_out_line_oe;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("pin driven after reset");
    property p_high_phase; $rose(serial_clk_out) |-> serial_clk_out[*4] ##1 !serial_clk_out;
    endproperty
    a_high_phase: assert property (p_high_phase) else $error("clock high phase wrong");
    property p_low_phase; $fell(serial_clk_out) |-> !serial_clk_out[*4]; endproperty
    a_low_phase: assert property (p_low_phase) else $error("clock low phase short");
    property p_out_stable; serial_clk_out && $past(serial_clk_out) |-> $stable(ctrl_out_line_out);
    endproperty
    a_out_stable: assert property (p_out_stable) else $error("data moved in high phase");
    property p_periph_stable;
        serial_clk_out && $past(serial_clk_out) |-> $stable(periph_out_line_out);
    endproperty
    a_periph_stable: assert property (p_periph_stable) else $error("periph data moved");
    property p_status_zero;
        psel && !penable && !pwrite && paddr == st_addr |=> prdata[4:0] == 5'h00;
    endproperty
    a_status_zero: assert property (p_status_zero) else $error("status low bits set");
    property p_irq_cause; $rose(irq) |-> serial_clk_out || $past(psel && penable && pwrite);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
    property p_irq_drop; $fell(irq) |-> $past(psel && penable); endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq fell without access");
    c_frame: cover property ($rose(serial_clk_out));
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
endmodule
bind spi_transmit_gate_and_status spi_gate_asserts spi_gate_asserts_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ctrl_out_line_in,
    .ctrl_out_line_out, .ctrl_out_line_oe, .periph_out_line_in, .periph_out_line_out,
    .periph_out_line_oe, .serial_clk_in, .serial_clk_out, .serial_clk_oe, .irq);

//--- bench/spi_transmit_gate_and_status_test.sv
// Purpose: self-checking bench for gate, status flags and shared irq
// Assumes: zero-wait apb, block as master against the far-side model
// Notes: read expectations queued by the driver, checked by the monitor
module spi_transmit_gate_and_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] a_cfg = spi_gate_pkg::idx_config << 2;
    localparam logic [31:0] a_op = spi_gate_pkg::idx_op_ctl << 2;
    localparam logic [31:0] a_st = spi_gate_pkg::idx_status << 2;
    localparam logic [31:0] a_rx = spi_gate_pkg::idx_rx_hold << 2;
    localparam logic [31:0] a_tx = spi_gate_pkg::idx_tx_hold << 2;
    localparam logic [31:0] a_is = spi_gate_pkg::idx_irq_status << 2;
    localparam logic [31:0] a_pin = spi_gate_pkg::idx_pin_cfg << 2;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, seed;
    logic c_out, c_oe, p_out, p_oe, sclk, sclk_oe, irq, far_out;
    logic [7:0] far_tx, far_rx, a_byte;
    logic [32:0] q[$];
    int mismatches, total_checks, cyc;
    spi_transmit_gate_and_status spi_transmit_gate_and_status_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ctrl_out_line_in(1'b0), .ctrl_out_line_out(c_out), .ctrl_out_line_oe(c_oe),
        .periph_out_line_in(far_out), .periph_out_line_out(p_out), .periph_out_line_oe(p_oe),
        .serial_clk_in(1'b0), .serial_clk_out(sclk), .serial_clk_oe(sclk_oe), .irq(irq));
    spi_far_end spi_far_end_i (.pclk(pclk), .presetn(presetn), .sclk(sclk), .din(c_out),
        .din_oe(c_oe), .tx_byte(far_tx), .dout(far_out), .rx_byte(far_rx));
    always #4 pclk = ~pclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic end_sim;
        if (mismatches == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string n, input logic [32:0] s, input logic [32:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic err = 1'b0);
        q.push_back({err, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic rises(input int n);
        repeat (n) @(posedge sclk);
    endtask
    task automatic settle;
        @(negedge sclk);
        @(posedge pclk);
        @(negedge pclk);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) check("read", {pslverr, prdata}, q.pop_front());
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'he13c2a3b;
        far_tx = 8'h00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(a_op, 32'h0000_0000);
        rd(a_st, 32'h0000_0000);
        rd(32'h0000_0ffc, 32'h0000_0000, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(a_op, {29'h0, i[1], i[0], 1'b0});
            wr(a_pin, {30'h0, {2{i[2]}}});
            @(negedge pclk);
            check("ctrl_oe", c_oe, i[0] & i[1] & !i[2]);
            check("periph_oe", p_oe, i[0] & !i[1] & !i[2]);
            @(posedge pclk);
        end
        wr(a_pin, 32'h0000_0000);
        seed = xs(seed);
        a_byte = seed[7:0];
        far_tx <= seed[15:8];
        wr(a_op, 32'h0000_0017);
        wr(a_tx, {24'h0, a_byte});
        rd(a_st, 32'h0000_0020);
        wr(a_cfg, 32'h0000_0080);
        rises(8);
        settle();
        check("far_rx", far_rx, a_byte);
        check("irq", irq, 1'b1);
        @(posedge pclk);
        rd(a_st, 32'h0000_0040);
        wr(a_op, 32'h0000_0016);
        @(negedge pclk);
        check("irq", irq, 1'b0);
        @(posedge pclk);
        rd(a_st, 32'h0000_0040);
        seed = xs(seed);
        far_tx <= seed[7:0];
        wr(a_tx, {24'h0, seed[15:8]});
        rises(2);
        wr(a_op, 32'h0000_0014);
        @(negedge pclk);
        check("ctrl_oe", c_oe, 1'b0);
        rises(6);
        settle();
        check("irq", irq, 1'b1);
        @(posedge pclk);
        rd(a_st, 32'h0000_00c0);
        wr(a_is, 32'h0000_0003);
        wr(a_tx, {24'h0, seed[23:16]});
        rises(8);
        settle();
        check("irq", irq, 1'b0);
        @(posedge pclk);
        rd(a_st, 32'h0000_00c0);
        wr(a_st, 32'h0000_0000);
        rd(a_st, 32'h0000_00c0);
        wr(a_st, 32'h0000_0080);
        rd(a_st, 32'h0000_0040);
        wr(a_cfg, 32'h0000_0000);
        rd(a_st, 32'h0000_0000);
        rd(a_rx, {24'h0, far_tx});
        repeat (2) @(posedge pclk);
        end_sim();
    end
endmodule
